/* File: ifb_pkg.sv */
package ifb_pkg;

  localparam int FLAG_W        = 16;
  localparam int NUM_FLAG_REGS = 3;
  localparam int NUM_REGS      = 6;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int IDX_W         = 3;

  typedef logic [FLAG_W-1:0] ifb_word_type;

  // Byte offsets on the register bus, one aligned word each.
  localparam logic [ADDR_W-1:0] OFF_FLAGS_0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK_0  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MASK_1  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MASK_2  = 8'h14;

  // Word index field of the address and the highest mapped index.
  localparam int               IDX_LSB  = 2;
  localparam int               IDX_MSB  = 4;
  localparam logic [IDX_W-1:0] LAST_IDX = 3'h5;

  // Implemented bit positions of each flag register.
  localparam ifb_word_type IMPL_FLAGS_0 = 16'h3fef;
  localparam ifb_word_type IMPL_FLAGS_1 = 16'hfedf;
  localparam ifb_word_type IMPL_FLAGS_2 = 16'h3fe3;
  localparam ifb_word_type IMPL_MASK [NUM_FLAG_REGS] = '{
    IMPL_FLAGS_0,
    IMPL_FLAGS_1,
    IMPL_FLAGS_2
  };

  localparam ifb_word_type FLAG_RESET = 16'h0000;
  localparam ifb_word_type MASK_RESET = 16'h0000;

endpackage

/* File: ifb_wr_if.sv */
`timescale 1ns/10ps
interface ifb_wr_if;
  import ifb_pkg::*;

  logic [NUM_REGS-1:0] wr_sel;
  ifb_word_type        wdata;

  modport src (
    output wr_sel,
    output wdata
  );

  modport dst (
    input wr_sel,
    input wdata
  );
endinterface

/* File: ifb_flag_reg.sv */
`timescale 1ns/10ps
module ifb_flag_reg
  import ifb_pkg::*;
#(
  parameter int unsigned  IDX  = 0,
  parameter ifb_word_type IMPL = 16'h0000
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  ifb_wr_if.dst                  wr,
  input  wire logic [FLAG_W-1:0] set_req,
  output ifb_word_type           flags
);

  wire          wr_en = wr.wr_sel[IDX];
  ifb_word_type next_flags;

  // A set in the same cycle as a write of zero must not be lost.
  assign next_flags = ((wr_en ? wr.wdata : flags) | set_req) & IMPL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    |(set_req & IMPL) |=>
      ((flags & $past(set_req & IMPL)) == $past(set_req & IMPL)))
    else $error("Flag set pulse was lost.");

  a_write_stores: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && set_req == 16'h0000) |=> flags == $past(wr.wdata & IMPL))
    else $error("Software write to a flag register was not stored.");

  a_flags_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!wr_en && set_req == 16'h0000) |=> $stable(flags))
    else $error("Flag changed without event or write.");

  a_unimpl_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (flags & ~IMPL) == 16'h0000)
    else $error("Unimplemented flag bit holds a one.");

endmodule

/* File: ifb_irq_gate.sv */
`timescale 1ns/10ps
module ifb_irq_gate
  import ifb_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  ifb_wr_if.dst        wr,
  input  ifb_word_type flags [NUM_FLAG_REGS],
  output ifb_word_type mask  [NUM_FLAG_REGS],
  output logic         irq
);

  logic [NUM_FLAG_REGS-1:0] pend;

  genvar i;
  generate
    for (i = 0; i < NUM_FLAG_REGS; i++) begin : g_mask
      // Mask bits of unimplemented flags stay zero so they never gate.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mask[i] <= MASK_RESET;
        end else if (wr.wr_sel[NUM_FLAG_REGS+i]) begin
          mask[i] <= wr.wdata & IMPL_MASK[i];
        end
      end
      assign pend[i] = |(flags[i] & mask[i]);
    end
  endgenerate

  assign irq = |pend;

  a_irq_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mask[0] == 16'h0000 && mask[1] == 16'h0000 && mask[2] == 16'h0000)
      |-> !irq)
    else $error("Interrupt raised with every source masked.");

endmodule

/* File: ifb_top.sv */
`timescale 1ns/10ps
module ifb_top
  import ifb_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              adc_done_flag_set,
  input  wire logic              uart_a_tx_flag_set,
  input  wire logic              uart_a_rx_flag_set,
  input  wire logic              serial_periph_a_event_flag_set,
  input  wire logic              serial_periph_a_fault_flag_set,
  input  wire logic              timer_c_flag_set,
  input  wire logic              timer_b_flag_set,
  input  wire logic              compare_out_b_flag_set,
  input  wire logic              capture_in_b_flag_set,
  input  wire logic              timer_a_flag_set,
  input  wire logic              compare_out_a_flag_set,
  input  wire logic              capture_in_a_flag_set,
  input  wire logic              ext_pin_a_flag_set,
  input  wire logic              uart_b_tx_flag_set,
  input  wire logic              uart_b_rx_flag_set,
  input  wire logic              ext_pin_c_flag_set,
  input  wire logic              timer_e_flag_set,
  input  wire logic              timer_d_flag_set,
  input  wire logic              compare_out_d_flag_set,
  input  wire logic              compare_out_c_flag_set,
  input  wire logic              capture_in_h_flag_set,
  input  wire logic              capture_in_g_flag_set,
  input  wire logic              ext_pin_b_flag_set,
  input  wire logic              pin_change_flag_set,
  input  wire logic              comparator_flag_set,
  input  wire logic              two_wire_a_master_flag_set,
  input  wire logic              two_wire_a_slave_flag_set,
  input  wire logic              parallel_port_flag_set,
  input  wire logic              compare_out_h_flag_set,
  input  wire logic              compare_out_g_flag_set,
  input  wire logic              compare_out_f_flag_set,
  input  wire logic              compare_out_e_flag_set,
  input  wire logic              capture_in_f_flag_set,
  input  wire logic              capture_in_e_flag_set,
  input  wire logic              capture_in_d_flag_set,
  input  wire logic              capture_in_c_flag_set,
  input  wire logic              serial_periph_b_event_flag_set,
  input  wire logic              serial_periph_b_fault_flag_set,
  output ifb_word_type           irq_flags_0,
  output ifb_word_type           irq_flags_1,
  output ifb_word_type           irq_flags_2,
  output logic                   irq
);

  ifb_wr_if wr_bus ();

  ifb_word_type     set_req  [NUM_FLAG_REGS];
  ifb_word_type     flags    [NUM_FLAG_REGS];
  ifb_word_type     mask     [NUM_FLAG_REGS];
  ifb_word_type     regs_all [NUM_REGS];
  ifb_word_type     rd_word;
  wire              setup_ph;
  wire              access_ph;
  wire              mapped;
  wire [IDX_W-1:0]  idx;

  // Bit order follows vector numbers, so each flag lines up with its
  // mask bit in the mask register of the same index.
  assign set_req[0] = {
    2'h0,
    adc_done_flag_set,
    uart_a_tx_flag_set,
    uart_a_rx_flag_set,
    serial_periph_a_event_flag_set,
    serial_periph_a_fault_flag_set,
    timer_c_flag_set,
    timer_b_flag_set,
    compare_out_b_flag_set,
    capture_in_b_flag_set,
    1'h0,
    timer_a_flag_set,
    compare_out_a_flag_set,
    capture_in_a_flag_set,
    ext_pin_a_flag_set
  };

  assign set_req[1] = {
    uart_b_tx_flag_set,
    uart_b_rx_flag_set,
    ext_pin_c_flag_set,
    timer_e_flag_set,
    timer_d_flag_set,
    compare_out_d_flag_set,
    compare_out_c_flag_set,
    1'h0,
    capture_in_h_flag_set,
    capture_in_g_flag_set,
    1'h0,
    ext_pin_b_flag_set,
    pin_change_flag_set,
    comparator_flag_set,
    two_wire_a_master_flag_set,
    two_wire_a_slave_flag_set
  };

  assign set_req[2] = {
    2'h0,
    parallel_port_flag_set,
    compare_out_h_flag_set,
    compare_out_g_flag_set,
    compare_out_f_flag_set,
    compare_out_e_flag_set,
    capture_in_f_flag_set,
    capture_in_e_flag_set,
    capture_in_d_flag_set,
    capture_in_c_flag_set,
    3'h0,
    serial_periph_b_event_flag_set,
    serial_periph_b_fault_flag_set
  };

  // Bus decode. Accesses complete in one access cycle, so pready is tied
  // high and the master never waits.
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign idx       = paddr[IDX_MSB:IDX_LSB];
  assign mapped    = (paddr[1:0] == 2'h0) &&
                     (paddr[ADDR_W-1:IDX_MSB+1] == 3'h0) &&
                     (idx <= LAST_IDX);
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;

  // Upper write lanes carry no state and are ignored.
  assign wr_bus.wdata = pwdata[FLAG_W-1:0];

  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_sel
      assign wr_bus.wr_sel[r] = access_ph && pwrite && mapped &&
                                (idx == IDX_W'(r));
    end
    for (r = 0; r < NUM_FLAG_REGS; r++) begin : g_flag
      ifb_flag_reg #(
        .IDX  (r),
        .IMPL (IMPL_MASK[r])
      ) u_flag (
        .pclk    (pclk),
        .presetn (presetn),
        .wr      (wr_bus.dst),
        .set_req (set_req[r]),
        .flags   (flags[r])
      );
      assign regs_all[r]               = flags[r];
      assign regs_all[NUM_FLAG_REGS+r] = mask[r];
    end
  endgenerate

  ifb_irq_gate u_gate (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (wr_bus.dst),
    .flags   (flags),
    .mask    (mask),
    .irq     (irq)
  );

  assign rd_word     = mapped ? regs_all[idx] : 16'h0000;
  assign irq_flags_0 = flags[0];
  assign irq_flags_1 = flags[1];
  assign irq_flags_2 = flags[2];

  // Read data is sampled in the setup cycle; an event landing during the
  // access cycle shows on the next read, never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= {16'h0000, rd_word};
    end
  end

  a_adc_done_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    adc_done_flag_set |=> irq_flags_0[13])
    else $error("Adc done event did not set register 0 bit 13.");

  a_ext_pin_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    ext_pin_a_flag_set |=> irq_flags_0[0])
    else $error("Ext pin a event did not set register 0 bit 0.");

  a_reg0_top_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_flags_0[15:14] == 2'h0 && irq_flags_0[4] == 1'b0)
    else $error("Unimplemented bit of register 0 reads one.");

  a_uart_b_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    uart_b_tx_flag_set |=> irq_flags_1[15] ##1
      (irq_flags_1[15] || $past(wr_bus.wr_sel[1])))
    else $error("Uart b tx event did not set register 1 bit 15.");

  a_pin_change_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pin_change_flag_set && !wr_bus.wr_sel[1]) |=> irq_flags_1[3] &&
      irq_flags_1[5] == 1'b0 && irq_flags_1[8] == 1'b0)
    else $error("Pin change event mapped wrongly in register 1.");

  a_par_port_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    parallel_port_flag_set |=> irq_flags_2[13])
    else $error("Parallel port event did not set register 2 bit 13.");

  a_spi_b_fault: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_periph_b_fault_flag_set |=> irq_flags_2[0])
    else $error("Spi b fault event did not set register 2 bit 0.");

  a_reg2_gap_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_flags_2[4:2] == 3'h0 && irq_flags_2[15:14] == 2'h0)
    else $error("Unimplemented bit of register 2 reads one.");

  a_read_flags0: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && paddr == OFF_FLAGS_0) |=>
      prdata == {16'h0000, $past(irq_flags_0)})
    else $error("Read of flag register 0 returned a wrong value.");

  a_clear_by_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && paddr == OFF_FLAGS_2 &&
     pwdata[15:0] == 16'h0000 && set_req[2] == 16'h0000)
      |=> irq_flags_2 == 16'h0000)
    else $error("Writing zero did not clear flag register 2.");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && !mapped) |-> pslverr && wr_bus.wr_sel == 6'h00)
    else $error("Unmapped access was not refused.");

  a_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    (irq_flags_1[4] && mask[1][4]) |-> irq)
    else $error("Unmasked pending flag did not raise the interrupt.");

  a_timer_c_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    timer_c_flag_set |=> irq_flags_0[8])
    else $error("Timer c event did not set register 0 bit 8.");

  a_read_top_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && paddr == OFF_FLAGS_0) |=>
      prdata[15:14] == 2'h0)
    else $error("Read of register 0 returned a one in bits 15 and 14.");

  a_slave_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    two_wire_a_slave_flag_set |=> irq_flags_1[0])
    else $error("Two wire slave event did not set register 1 bit 0.");

  a_capture_f_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    capture_in_f_flag_set |=> irq_flags_2[8])
    else $error("Capture f event did not set register 2 bit 8.");

  a_read_gap_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && paddr == OFF_FLAGS_2) |=>
      prdata[4:2] == 3'h0)
    else $error("Read of register 2 returned a one in bits 4 to 2.");

  a_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    (access_ph && pwrite && paddr == OFF_FLAGS_1 && set_req[1] == 16'h0000)
      |=> irq_flags_1 == ($past(pwdata[15:0]) & IMPL_FLAGS_1))
    else $error("Write to flag register 1 was not stored.");

  a_refused_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && !mapped) |=> prdata == 32'h0000_0000)
    else $error("Read of an unmapped address returned data.");

endmodule

/* File: ifb_evt_src.sv */
`timescale 1ns/10ps
module ifb_evt_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rnd_en,
  input  wire logic [47:0] rnd,
  input  wire logic [47:0] fire,
  output logic      [47:0] ev
);
  // Sources exist only at implemented positions, so no pulse ever lands
  // on a reserved bit and the flag map is exercised exactly.
  localparam logic [47:0] SRC = 48'h3fe3_fedf_3fef;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ev <= 48'h0;
    else
      ev <= (fire | (rnd_en ? rnd : 48'h0)) & SRC;
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  import ifb_pkg::*;
  localparam logic [15:0] IMP [3] = '{16'h3fef, 16'hfedf, 16'h3fe3};
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic        [7:0]  paddr = 8'h00;
  logic        [31:0] pwdata = 32'h0;
  logic               rnd_en = 1'b0;
  logic        [47:0] rnd = 48'h0;
  logic        [47:0] fire = 48'h0;
  logic        [47:0] ev;
  logic        [31:0] prdata;
  logic               pready;
  logic               pslverr;
  logic               irq;
  ifb_word_type       f0;
  ifb_word_type       f1;
  ifb_word_type       f2;
  logic        [15:0] mf [3];
  logic        [15:0] mm [3];
  wire                irq_exp = |((mf[0] & mm[0]) | (mf[1] & mm[1]) |
                                  (mf[2] & mm[2]));
  logic        [15:0] rd_exp = 16'h0;
  integer             seed = 32'h6c1f;
  int                 miscompares = 0;
  int                 n_tests = 0;
  wire                mapped = paddr[1:0] == 2'b00 && paddr < 8'h18;
  wire         [2:0]  ix = paddr[4:2];
  wire                wr_hit = psel && penable && pwrite && pready && mapped;

  always #2 pclk = ~pclk;

  ifb_evt_src SRC (.pclk(pclk), .presetn(presetn), .rnd_en(rnd_en),
                   .rnd(rnd), .fire(fire), .ev(ev));

  ifb_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .irq_flags_0(f0), .irq_flags_1(f1), .irq_flags_2(f2),
    .adc_done_flag_set(ev[13]), .uart_a_tx_flag_set(ev[12]),
    .uart_a_rx_flag_set(ev[11]), .serial_periph_a_event_flag_set(ev[10]),
    .serial_periph_a_fault_flag_set(ev[9]), .timer_c_flag_set(ev[8]),
    .timer_b_flag_set(ev[7]), .compare_out_b_flag_set(ev[6]),
    .capture_in_b_flag_set(ev[5]), .timer_a_flag_set(ev[3]),
    .compare_out_a_flag_set(ev[2]), .capture_in_a_flag_set(ev[1]),
    .ext_pin_a_flag_set(ev[0]), .uart_b_tx_flag_set(ev[31]),
    .uart_b_rx_flag_set(ev[30]), .ext_pin_c_flag_set(ev[29]),
    .timer_e_flag_set(ev[28]), .timer_d_flag_set(ev[27]),
    .compare_out_d_flag_set(ev[26]), .compare_out_c_flag_set(ev[25]),
    .capture_in_h_flag_set(ev[23]), .capture_in_g_flag_set(ev[22]),
    .ext_pin_b_flag_set(ev[20]), .pin_change_flag_set(ev[19]),
    .comparator_flag_set(ev[18]), .two_wire_a_master_flag_set(ev[17]),
    .two_wire_a_slave_flag_set(ev[16]), .parallel_port_flag_set(ev[45]),
    .compare_out_h_flag_set(ev[44]), .compare_out_g_flag_set(ev[43]),
    .compare_out_f_flag_set(ev[42]), .compare_out_e_flag_set(ev[41]),
    .capture_in_f_flag_set(ev[40]), .capture_in_e_flag_set(ev[39]),
    .capture_in_d_flag_set(ev[38]), .capture_in_c_flag_set(ev[37]),
    .serial_periph_b_event_flag_set(ev[33]),
    .serial_periph_b_fault_flag_set(ev[32])
  );

  // Reference state; a set arriving with a write is applied after it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        mf[i] <= 16'h0;
        mm[i] <= 16'h0;
      end
    end else begin
      if (psel && !penable)
        rd_exp <= !mapped ? 16'h0 : (ix < 3'd3) ? mf[ix] : mm[ix - 3'd3];
      for (int i = 0; i < 3; i++) begin
        mf[i] <= ((wr_hit && ix == i) ? pwdata[15:0] & IMP[i] : mf[i])
                 | (ev[16*i +: 16] & IMP[i]);
        if (wr_hit && ix == i + 3)
          mm[i] <= pwdata[15:0] & IMP[i];
      end
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(negedge pclk) begin
    if (presetn) begin
      check(f0, mf[0]);
      check(f1, mf[1]);
      check(f2, mf[2]);
      check(irq, irq_exp);
    end
  end

  // Leaves the access phase standing; the caller follows with apb or idle
  // in the same time step so no signal is driven twice per edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    check(pslverr, !(a[1:0] == 2'b00 && a < 8'h18));
    if (!w) check(prdata, {16'h0, rd_exp});
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    logic [7:0] a;
    fork
      begin
        repeat (10000) @(posedge pclk);
        miscompares++;
        complete_run();
      end
    join_none
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 6; r++) apb(1'b0, 8'(4 * r), 32'h0);
    for (int r = 0; r < 6; r++) apb(1'b1, 8'(4 * r), 32'hffffffff);
    for (int r = 0; r < 6; r++) apb(1'b0, 8'(4 * r), 32'h0);
    for (int r = 0; r < 3; r++) apb(1'b1, 8'(4 * r), 32'h0);
    idle();
    for (int b = 0; b < 48; b++) begin
      if (IMP[b / 16][b % 16]) begin
        a = 8'(4 * (b / 16));
        fire <= 48'h1 << b;
        idle();
        fire <= 48'h0;
        idle();
        apb(1'b0, a, 32'h0);
        check(prdata, 32'h1 << (b % 16));
        fire <= 48'h1 << b;
        fork
          apb(1'b1, a, 32'h0);
          begin
            @(posedge pclk);
            fire <= 48'h0;
          end
        join
        apb(1'b0, a, 32'h0);
        check(prdata, 32'h1 << (b % 16));
        apb(1'b1, a, 32'h0);
        apb(1'b0, a, 32'h0);
        idle();
      end
    end
    rnd_en <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      rnd <= 48'({$random(seed), $random(seed)} &
                 {$random(seed), $random(seed)} &
                 {$random(seed), $random(seed)});
      if (($random(seed) & 3) == 0)
        a = 8'($random(seed)) & 8'h1f;
      else
        a = 8'(4 * ({$random(seed)} % 6));
      apb(1'($random(seed)), a, $random(seed));
    end
    idle();
    rnd_en <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 6; r++) apb(1'b0, 8'(4 * r), 32'h0);
    idle();
    complete_run();
  end
endmodule
